//--- include/stc_pkg.sv
// Constants shared by the tape drive controller and its time pulse unit.
// Assumes a single core clock at the rate given by CLK_PERIOD_NS.
package stc_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int GO_DELAY_NS = 200;
	// Least time: round up
	localparam int GO_DELAY_CYC =
		(GO_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int UTS_DELAY_MS = 120;
	localparam int UTS_DELAY_CYC = UTS_DELAY_MS * (1000000 / CLK_PERIOD_NS);
	localparam int NOISE_DELAY_US = 10;
	localparam int NOISE_DELAY_CYC =
		(NOISE_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Half of the 16.6 us format square wave; longest time, round down
	localparam int FMT_HALF_NS = 8300;
	localparam int FMT_HALF_CYC = FMT_HALF_NS / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// Instruction codes (low three instruction bits)
	// ------------------------------------------------------------
	localparam logic [2:0] OP_SKIP_LINE = 3'h1;
	localparam logic [2:0] OP_SKIP_TERR = 3'h2;
	localparam logic [2:0] OP_SKIP_WORD = 3'h3;
	localparam logic [2:0] OP_LOAD_CMD = 3'h4;
	localparam logic [2:0] OP_LOAD_DATA = 3'h5;
	localparam logic [2:0] OP_READ_CMD = 3'h6;
	localparam logic [2:0] OP_READ_DATA = 3'h7;

	// ------------------------------------------------------------
	// Command register layout (bus bits 3..0)
	// ------------------------------------------------------------
	localparam int CMD_W = 4;
	localparam int CMD_UNIT = 3;
	localparam int CMD_DIR = 2;
	localparam int CMD_RUN = 1;
	localparam int CMD_RW = 0;
	localparam logic [3:0] CMD_RESET = 4'h0;

	// ------------------------------------------------------------
	// Read-command word layout
	// ------------------------------------------------------------
	localparam int WORD_W = 12;
	localparam int MARK_W = 6;
	localparam int AC_MARK_LSB = 6;
	localparam int AC_ERR_BIT = 5;
	localparam int AC_WLOCK_BIT = 4;
	localparam int AC_CMD_LSB = 0;

	// ------------------------------------------------------------
	// Tape line framing
	// ------------------------------------------------------------
	localparam int TRACKS = 3;
	localparam logic [1:0] LAST_LINE = 2'h3;
	localparam logic [11:0] WORD_RESET = 12'h000;
	localparam logic [5:0] MARK_RESET = 6'h00;

endpackage

//--- verilog/stc_time_pulse.sv
// Time pulse generator: one pulse per timing track edge, or per edge of
// an internal square wave while formatting. Timing track is asynchronous.
`timescale 1ns/1ns
module stc_time_pulse
	import stc_pkg::*;
#(
	parameter int NOISE_CYC = NOISE_DELAY_CYC,
	parameter int FMT_CYC = FMT_HALF_CYC
)
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic system_clear,
	input wire logic timing_track_in,
	input wire logic up_to_speed,
	input wire logic writing,
	input wire logic formatting,
	output logic time_pulse,
	output logic write_timing_track
);

	if (NOISE_CYC < 1 || FMT_CYC < 1)
		$error("stc_time_pulse: delay counts must be at least one");

	localparam int NW = $clog2(NOISE_CYC + 1);
	localparam int FW = $clog2(FMT_CYC + 1);
	localparam logic [NW-1:0] NOISE_LOAD = NW'(NOISE_CYC);
	localparam logic [FW-1:0] FMT_LOAD = FW'(FMT_CYC);

	logic tt_meta_reg, tt_sync_reg, tt_prev_reg;
	logic [NW-1:0] noise_reg;
	logic [FW-1:0] fmt_cnt_reg;
	logic edge_seen, fmt_edge, pulse_next;

	// ------------------------------------------------------------
	// Timing track synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge arst_n)
		if (!arst_n)
		begin
			tt_meta_reg <= 1'b0;
			tt_sync_reg <= 1'b0;
			tt_prev_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			tt_meta_reg <= timing_track_in;
			tt_sync_reg <= tt_meta_reg;
			tt_prev_reg <= tt_sync_reg;
		end

	assign fmt_edge = formatting && fmt_cnt_reg == '0;
	assign edge_seen = formatting ? fmt_edge
		: (tt_sync_reg ^ tt_prev_reg) && noise_reg == '0;
	// both edges, only up to speed
	assign pulse_next = edge_seen && up_to_speed;

	// ------------------------------------------------------------
	// Pickup suppression and format clock
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge arst_n)
		if (!arst_n)
		begin
			noise_reg <= '0;
			fmt_cnt_reg <= '0;
			write_timing_track <= 1'b0;
			time_pulse <= 1'b0;
		end
		else if (clk_en)
		begin
			time_pulse <= pulse_next && !system_clear;
			if (system_clear)
				noise_reg <= '0;
			else if (pulse_next && writing && !formatting)
				noise_reg <= NOISE_LOAD;
			else if (noise_reg != '0)
				noise_reg <= noise_reg - NW'(1);
			if (system_clear || !formatting)
			begin
				fmt_cnt_reg <= FMT_LOAD;
				write_timing_track <= 1'b0;
			end
			else if (fmt_cnt_reg == '0)
			begin
				fmt_cnt_reg <= FMT_LOAD;
				write_timing_track <= !write_timing_track;
			end
			else
				fmt_cnt_reg <= fmt_cnt_reg - FW'(1);
		end

endmodule

//--- verilog/stc_ctrl.sv
// Tape drive controller: instruction decode, command, data and mark
// registers, flags and drive lines. Host strobes share core_clk; drive
// lines are asynchronous and are synchronised here.
//
// Summary of operation
// - Jumper match on pause raises internal I/O
// - Internal I/O blocks bus, enables decoding
// - Load command copies four bus bits
// - Unit bit picks drive zero or one
// - Direction bit: clear forward, set reverse
// - Run moves tape; go lags 200 ns
// - Read/write bit: clear read, set write
// - Load command clears error, starts delay
// - Motion change restarts 120 ms speed delay
// - Faults and clear force read mode
// - Mark bits shift in one per line
// - Mark register cleared at delay start
// - Read command returns mark, status, command
// - Line flag per line; cleared by transfers
// - Word flag every four lines; same clears
// - Missed service or overlap sets timing error
// - Status bit is error OR select fault
// - Write protect forces read; own status
// - Pulses on both timing edges when ready
// - Formatting writes timing and mark tracks
// - Three tracks carry interleaved word bits
// - Write gate needs write and speed
// - Ten microsecond pickup suppression delay
// - Processor stop halts drives, forces read
`timescale 1ns/1ns
module stc_ctrl
	import stc_pkg::*;
#(
	parameter int UTS_CYCLES = UTS_DELAY_CYC,
	parameter int NOISE_CYCLES = NOISE_DELAY_CYC
)
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic system_clear,
	input wire logic io_pause,
	input wire logic [1:0] md_dev,
	input wire logic [2:0] md_op,
	input wire logic code_select_bit_a,
	input wire logic code_select_bit_b,
	input wire logic [11:0] data_bus,
	output logic internal_io,
	output logic instr_decode_enable,
	output logic skip,
	output logic ac_load,
	output logic [11:0] ac_out,
	output logic unit_sel,
	output logic dir_reverse,
	output logic go,
	output logic stop_all,
	output logic write_data_gate,
	output logic write_track0,
	output logic write_track1,
	output logic write_track2,
	output logic write_timing_track,
	output logic write_mark_track,
	output logic up_to_speed,
	output logic line_done_flag,
	output logic word_done_flag,
	output logic timing_error,
	input wire logic read_track0,
	input wire logic read_track1,
	input wire logic read_track2,
	input wire logic timing_track_in,
	input wire logic mark_track_in,
	input wire logic sel_err,
	input wire logic write_lockout,
	input wire logic power_ok,
	input wire logic proc_run,
	input wire logic format_write_setting
);

	if (UTS_CYCLES < 1 || NOISE_CYCLES < 1)
		$error("stc_ctrl: delay counts must be at least one");

	localparam int UW = $clog2(UTS_CYCLES + 1);
	localparam logic [UW-1:0] UTS_LOAD = UW'(UTS_CYCLES);
	localparam int GW = $clog2(GO_DELAY_CYC + 1);
	localparam logic [GW-1:0] GO_LOAD = GW'(GO_DELAY_CYC);
	localparam int NSYNC = 9;
	// Power-ok and run idle high: no false stop pulse after reset
	localparam logic [NSYNC-1:0] SYNC_RST = 9'h006;

	// ------------------------------------------------------------
	// Drive line synchronisers
	// ------------------------------------------------------------
	logic [NSYNC-1:0] pin_raw, pin_meta_reg, pin_sync_reg;
	logic rd0_s, rd1_s, rd2_s, mark_s, sel_s, wlock_s, pok_s, run_s, fmt_s;

	assign pin_raw = {read_track0, read_track1, read_track2, mark_track_in,
		sel_err, write_lockout, power_ok, proc_run, format_write_setting};

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++)
		begin : g_sync
			always_ff @(posedge core_clk or negedge arst_n)
				if (!arst_n)
				begin
					pin_meta_reg[gi] <= SYNC_RST[gi];
					pin_sync_reg[gi] <= SYNC_RST[gi];
				end
				else if (clk_en)
				begin
					pin_meta_reg[gi] <= pin_raw[gi];
					pin_sync_reg[gi] <= pin_meta_reg[gi];
				end
		end
	endgenerate

	assign {rd0_s, rd1_s, rd2_s, mark_s, sel_s, wlock_s, pok_s, run_s,
		fmt_s} = pin_sync_reg;

	// ------------------------------------------------------------
	// Instruction decode
	// ------------------------------------------------------------
	logic op_lc, op_ld, op_rc, op_rd, op_xfer;

	assign internal_io = io_pause
		&& md_dev == {code_select_bit_a, code_select_bit_b};
	assign instr_decode_enable = internal_io;
	assign op_lc = instr_decode_enable && md_op == OP_LOAD_CMD;
	assign op_ld = instr_decode_enable && md_op == OP_LOAD_DATA;
	assign op_rc = instr_decode_enable && md_op == OP_READ_CMD;
	assign op_rd = instr_decode_enable && md_op == OP_READ_DATA;
	assign op_xfer = op_ld || op_rc || op_rd;

	// ------------------------------------------------------------
	// Command register
	// ------------------------------------------------------------
	logic [CMD_W-1:0] cmd_reg;
	logic motion_change, force_read, stop_next;

	// Only unit, direction and run restart the speed delay
	assign motion_change = op_lc
		&& data_bus[CMD_UNIT:CMD_RUN] != cmd_reg[CMD_UNIT:CMD_RUN];
	assign stop_next = !run_s;
	assign force_read = sel_s || timing_error || wlock_s || !pok_s
		|| stop_all;

	always_ff @(posedge core_clk or negedge arst_n)
		if (!arst_n)
			cmd_reg <= CMD_RESET;
		else if (clk_en)
		begin
			if (system_clear)
				cmd_reg <= CMD_RESET;
			else
			begin
				if (op_lc)
					cmd_reg <= data_bus[CMD_W-1:0];
				if (stop_all)
					cmd_reg[CMD_RUN] <= 1'b0;
				if (force_read)
					cmd_reg[CMD_RW] <= 1'b0;
			end
		end

	assign unit_sel = cmd_reg[CMD_UNIT];
	assign dir_reverse = cmd_reg[CMD_DIR];

	// ------------------------------------------------------------
	// Go delay, stop-all and up-to-speed
	// ------------------------------------------------------------
	logic [GW-1:0] go_cnt_reg;
	logic [UW-1:0] uts_cnt_reg;

	always_ff @(posedge core_clk or negedge arst_n)
		if (!arst_n)
		begin
			go_cnt_reg <= '0;
			go <= 1'b0;
			stop_all <= 1'b0;
		end
		else if (clk_en)
		begin
			stop_all <= stop_next && !system_clear;
			if (system_clear)
				go_cnt_reg <= '0;
			else if (op_lc)
				go_cnt_reg <= GO_LOAD;
			else if (go_cnt_reg != '0)
				go_cnt_reg <= go_cnt_reg - GW'(1);
			go <= cmd_reg[CMD_RUN] && go_cnt_reg == '0 && !op_lc
				&& !system_clear;
		end

	always_ff @(posedge core_clk or negedge arst_n)
		if (!arst_n)
		begin
			uts_cnt_reg <= '0;
			up_to_speed <= 1'b0;
		end
		else if (clk_en)
		begin
			if (system_clear || motion_change)
			begin
				uts_cnt_reg <= UTS_LOAD;
				up_to_speed <= 1'b0;
			end
			else if (!cmd_reg[CMD_RUN])
				up_to_speed <= 1'b0;
			else if (uts_cnt_reg != '0)
				uts_cnt_reg <= uts_cnt_reg - UW'(1);
			else
				up_to_speed <= 1'b1;
		end

	// ------------------------------------------------------------
	// Time pulses
	// ------------------------------------------------------------
	logic time_pulse, writing, formatting;

	assign writing = cmd_reg[CMD_RW];
	assign formatting = fmt_s && writing;

	stc_time_pulse #(
		.NOISE_CYC(NOISE_CYCLES),
		.FMT_CYC(FMT_HALF_CYC)
	) u_tpg (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.clk_en(clk_en),
		.system_clear(system_clear),
		.timing_track_in(timing_track_in),
		.up_to_speed(up_to_speed),
		.writing(writing),
		.formatting(formatting),
		.time_pulse(time_pulse),
		.write_timing_track(write_timing_track)
	);

	// ------------------------------------------------------------
	// Line framing, data and mark registers
	// ------------------------------------------------------------
	logic [1:0] line_cnt_reg;
	logic [WORD_W-1:0] data_reg, shift_reg;
	logic [MARK_W-1:0] mark_code_reg;
	logic [TRACKS-1:0] rd_line;
	logic word_end;

	// Track 0 holds the leading bit of each three-bit line
	assign rd_line = {rd0_s, rd1_s, rd2_s};
	assign word_end = time_pulse && line_cnt_reg == LAST_LINE;

	always_ff @(posedge core_clk or negedge arst_n)
		if (!arst_n)
		begin
			line_cnt_reg <= '0;
			shift_reg <= WORD_RESET;
			data_reg <= WORD_RESET;
		end
		else if (clk_en)
		begin
			if (system_clear)
			begin
				line_cnt_reg <= '0;
				shift_reg <= WORD_RESET;
				data_reg <= WORD_RESET;
			end
			else
			begin
				if (!up_to_speed)
					line_cnt_reg <= '0;
				else if (time_pulse)
					line_cnt_reg <= line_cnt_reg + 2'h1;
				if (writing)
				begin
					if (!up_to_speed || word_end)
						shift_reg <= data_reg;
					else if (time_pulse)
						shift_reg <= {shift_reg[WORD_W-4:0], 3'h0};
				end
				else if (time_pulse)
					shift_reg <= {shift_reg[WORD_W-4:0], rd_line};
				if (op_ld)
					data_reg <= data_bus;
				else if (word_end && !writing)
					data_reg <= {shift_reg[WORD_W-4:0], rd_line};
			end
		end

	always_ff @(posedge core_clk or negedge arst_n)
		if (!arst_n)
			mark_code_reg <= MARK_RESET;
		else if (clk_en)
		begin
			if (system_clear || motion_change)
				mark_code_reg <= MARK_RESET;
			else if (time_pulse && !writing)
				mark_code_reg <= {mark_code_reg[MARK_W-2:0], mark_s};
		end

	// ------------------------------------------------------------
	// Flags
	// ------------------------------------------------------------
	logic terr_set;

	assign terr_set = word_end && (word_done_flag || op_xfer);

	always_ff @(posedge core_clk or negedge arst_n)
		if (!arst_n)
		begin
			line_done_flag <= 1'b0;
			word_done_flag <= 1'b0;
			timing_error <= 1'b0;
		end
		else if (clk_en)
		begin
			if (system_clear)
			begin
				line_done_flag <= 1'b0;
				word_done_flag <= 1'b0;
				timing_error <= 1'b0;
			end
			else
			begin
				if (!up_to_speed)
					line_done_flag <= 1'b0;
				else if (time_pulse)
					line_done_flag <= 1'b1;
				else if (op_xfer)
					line_done_flag <= 1'b0;
				if (!up_to_speed)
					word_done_flag <= 1'b0;
				else if (word_end)
					word_done_flag <= 1'b1;
				else if (op_xfer)
					word_done_flag <= 1'b0;
				if (terr_set)
					timing_error <= 1'b1;
				else if (op_lc)
					timing_error <= 1'b0;
			end
		end

	// ------------------------------------------------------------
	// Accumulator answers and skips
	// ------------------------------------------------------------
	logic [WORD_W-1:0] rc_word;

	always_comb
	begin
		rc_word = '0;
		rc_word[AC_MARK_LSB +: MARK_W] = mark_code_reg;
		rc_word[AC_ERR_BIT] = timing_error || sel_s;
		rc_word[AC_WLOCK_BIT] = wlock_s;
		rc_word[AC_CMD_LSB +: CMD_W] = cmd_reg;
	end

	always_ff @(posedge core_clk or negedge arst_n)
		if (!arst_n)
		begin
			ac_out <= WORD_RESET;
			ac_load <= 1'b0;
			skip <= 1'b0;
		end
		else if (clk_en)
		begin
			ac_load <= (op_rc || op_rd) && !system_clear;
			if (op_rc)
				ac_out <= rc_word;
			else if (op_rd)
				ac_out <= data_reg;
			skip <= instr_decode_enable && !system_clear
				&& ((md_op == OP_SKIP_LINE && line_done_flag)
				|| (md_op == OP_SKIP_TERR && timing_error)
				|| (md_op == OP_SKIP_WORD && word_done_flag));
		end

	// ------------------------------------------------------------
	// Write lines to the drive
	// ------------------------------------------------------------
	logic gate_next;

	assign gate_next = writing && up_to_speed && !system_clear;

	always_ff @(posedge core_clk or negedge arst_n)
		if (!arst_n)
		begin
			write_data_gate <= 1'b0;
			write_track0 <= 1'b0;
			write_track1 <= 1'b0;
			write_track2 <= 1'b0;
			write_mark_track <= 1'b0;
		end
		else if (clk_en)
		begin
			write_data_gate <= gate_next;
			write_track0 <= gate_next && shift_reg[WORD_W-1];
			write_track1 <= gate_next && shift_reg[WORD_W-2];
			write_track2 <= gate_next && shift_reg[WORD_W-3];
			write_mark_track <= gate_next && formatting
				&& shift_reg[WORD_W-1];
		end

endmodule

//--- sim/stc_ctrl_chk.sv
// Port checker for the tape drive controller.
// Bound to stc_ctrl from the bench; one clock, async reset.
`timescale 1ns/1ns
module stc_ctrl_chk
	import stc_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic system_clear,
	input wire logic io_pause,
	input wire logic [1:0] md_dev,
	input wire logic [2:0] md_op,
	input wire logic code_select_bit_a,
	input wire logic code_select_bit_b,
	input wire logic [11:0] data_bus,
	input wire logic internal_io,
	input wire logic instr_decode_enable,
	input wire logic skip,
	input wire logic ac_load,
	input wire logic [11:0] ac_out,
	input wire logic unit_sel,
	input wire logic dir_reverse,
	input wire logic go,
	input wire logic stop_all,
	input wire logic write_data_gate,
	input wire logic write_track0,
	input wire logic write_track1,
	input wire logic write_track2,
	input wire logic up_to_speed,
	input wire logic line_done_flag,
	input wire logic word_done_flag,
	input wire logic timing_error
);
	// ----------------------------------------
	// Helper logic
	// ----------------------------------------
	// Go delay is longer than a repetition may count
	int go_wait;

	always_ff @(posedge core_clk or negedge arst_n)
		if (!arst_n)
			go_wait <= 0;
		else if (clk_en && internal_io && !system_clear
			&& md_op == OP_LOAD_CMD)
			go_wait <= GO_DELAY_CYC;
		else if (clk_en && go_wait != 0)
			go_wait <= go_wait - 1;

	// ----------------------------------------
	// Sequences
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	sequence s_take(logic [2:0] code);
		internal_io && clk_en && !system_clear && md_op == code;
	endsequence
	sequence s_go_held;
		!go [*8];
	endsequence

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_decode_match: assert property (
		internal_io == (io_pause && md_dev ==
		{code_select_bit_a, code_select_bit_b}))
		else $error("decode wrong");
	a_enable_follows: assert property (
		instr_decode_enable == internal_io)
		else $error("enable differs");
	a_go_delay: assert property (
		s_take(OP_LOAD_CMD) |=> s_go_held)
		else $error("go too early");
	a_go_wait: assert property (
		go_wait != 0 |-> !go)
		else $error("go inside delay");
	a_uts_drop: assert property (
		s_take(OP_LOAD_CMD) ##0 (data_bus[CMD_UNIT] != unit_sel)
		|=> !up_to_speed)
		else $error("speed not dropped");
	a_uts_run: assert property (
		$rose(up_to_speed) |-> go)
		else $error("speed without run");
	a_terr_clear: assert property (
		s_take(OP_LOAD_CMD) ##0 !up_to_speed |=> !timing_error)
		else $error("error not cleared");
	a_read_word: assert property (
		s_take(OP_READ_CMD) |=> ac_load && ac_out[CMD_UNIT] == unit_sel
		&& ac_out[CMD_DIR] == dir_reverse)
		else $error("read word wrong");
	a_flags_idle: assert property (
		!up_to_speed |=> !line_done_flag && !word_done_flag)
		else $error("flag while slow");
	a_skip_line: assert property (
		s_take(OP_SKIP_LINE) ##0 line_done_flag |=> skip)
		else $error("no skip");
	a_gate_speed: assert property (
		write_data_gate |-> $past(up_to_speed))
		else $error("gate without speed");
	a_wr_idle: assert property (
		!write_data_gate && !$past(write_data_gate)
		|-> !(write_track0 || write_track1 || write_track2))
		else $error("write while idle");
	a_stop_halts: assert property (
		stop_all |-> ##2 (!go && !write_data_gate))
		else $error("stop ignored");
endmodule

//--- sim/stc_tape_model.sv
// Drive model: streams lines while below line_limit, logs written lines.
// Timing track stands still between runs; released data lines invert.
`timescale 1ns/1ns
module stc_tape_model
	import stc_pkg::*;
(
	input wire logic [11:0] word,
	input wire logic [5:0] mark,
	input wire logic [31:0] line_limit,
	input wire logic write_track0,
	input wire logic write_track1,
	input wire logic write_track2,
	output logic timing_track_in,
	output logic read_track0,
	output logic read_track1,
	output logic read_track2,
	output logic mark_track_in,
	output logic [47:0] wr_hist,
	output int n_lines
);
	int k;
	initial
	begin
		timing_track_in = 1'b0;
		{read_track0, read_track1, read_track2, mark_track_in} = 4'h0;
		wr_hist = 48'h0;
		n_lines = 0;
		forever
		begin
			wait (n_lines < line_limit);
			k = n_lines % 4;
			{read_track0, read_track1, read_track2} = word[11 - 3 * k -: 3];
			mark_track_in = mark[5 - n_lines % 6];
			#40;
			timing_track_in = ~timing_track_in;
			// Written line is settled 70 ns into the next line
			#30;
			wr_hist = {wr_hist[44:0], write_track0, write_track1, write_track2};
			#10;
			n_lines++;
			if (n_lines >= line_limit)
				{read_track0, read_track1, read_track2, mark_track_in} =
					~{read_track0, read_track1, read_track2, mark_track_in};
		end
	end
endmodule

//--- sim/tb_simple_tape_drive_control.sv
// Bench for stc_ctrl with the drive model; self-checking.
// Needs stc_pkg, the design, checker and model compiled first.
`timescale 1ns/1ns
module tb_simple_tape_drive_control
	import stc_pkg::*;
;
	localparam int UTS_N = 20;
	logic core_clk, arst_n, system_clear, io_pause, internal_io, skip;
	logic [1:0] md_dev;
	logic [2:0] md_op;
	logic [11:0] data_bus, ac_out, word;
	logic [5:0] mark;
	logic [31:0] line_limit;
	logic [47:0] wr_hist;
	logic ac_load, unit_sel, dir_reverse, go, stop_all, write_data_gate;
	logic up_to_speed, write_track0, write_track1, write_track2;
	logic line_done_flag, word_done_flag, timing_error, read_track0;
	logic read_track1, read_track2, timing_track_in, mark_track_in;
	logic sel_err, write_lockout, power_ok, proc_run;
	logic format_write_setting, write_timing_track;
	int n_lines, err_count, n_compared;

	stc_ctrl #(.UTS_CYCLES(UTS_N), .NOISE_CYCLES(3)) i_dut (.core_clk,
		.arst_n, .clk_en(1'b1), .system_clear, .io_pause, .md_dev, .md_op,
		.code_select_bit_a(1'b1), .code_select_bit_b(1'b0), .data_bus,
		.internal_io, .instr_decode_enable(), .skip, .ac_load, .ac_out,
		.unit_sel, .dir_reverse, .go, .stop_all, .write_data_gate,
		.write_track0, .write_track1, .write_track2, .write_timing_track,
		.write_mark_track(), .up_to_speed, .line_done_flag, .word_done_flag,
		.timing_error, .read_track0, .read_track1, .read_track2,
		.timing_track_in, .mark_track_in, .sel_err, .write_lockout,
		.power_ok, .proc_run, .format_write_setting);
	stc_tape_model i_tape (.word, .mark, .line_limit, .write_track0,
		.write_track1, .write_track2, .timing_track_in, .read_track0,
		.read_track1, .read_track2, .mark_track_in, .wr_hist, .n_lines);

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Instruction carrying this block's code
	task automatic op(input logic [2:0] c, input logic [11:0] d);
		// An edge between strobes of back-to-back instructions
		tick(1);
		io_pause = 1'b1;
		md_dev = 2'h2;
		md_op = c;
		data_bus = d;
		tick(1);
		io_pause = 1'b0;
	endtask
	// Twelve lines, 60 steps of one cycle or one instruction; optional service of each word
	task automatic lines12(input logic service, input logic [2:0] c);
		line_limit = 32'(n_lines + 12);
		for (int i = 0; i < 60; i++)
		begin
			if (service && word_done_flag === 1'b1)
			begin
				op(c, word);
				if (c == OP_READ_DATA)
					chk(ac_out, word);
			end
			else
				tick(1);
		end
	endtask
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_decode();
		op(OP_READ_CMD, 12'h000);
		chk(12'({ac_load, ac_out[3:0]}), 12'(5'h10 | CMD_RESET));
		tick(1);
		md_dev = 2'h1;
		io_pause = 1'b1;
		tick(1);
		io_pause = 1'b0;
		chk(12'(ac_load), 12'h0);
	endtask
	task automatic t_cmd();
		logic [3:0] v, p;
		p = 4'h0;
		for (int i = 0; i < 16; i++)
		begin
			v = 4'(i);
			op(OP_LOAD_CMD, {8'h00, p[3:2], 1'b0, p[0]});
			op(OP_LOAD_CMD, {8'h00, v[3:2], 1'b0, v[0]});
			op(OP_LOAD_CMD, {8'h00, v});
			tick(12);
			chk(12'({unit_sel, dir_reverse, go}), 12'(v[3:1]));
			op(OP_READ_CMD, 12'h000);
			chk(12'(ac_out[3:0]), 12'(v));
			p = v;
		end
	endtask
	task automatic t_uts();
		int n;
		op(OP_LOAD_CMD, 12'h002);
		for (n = 0; n < 100 && up_to_speed !== 1'b1; n++)
			tick(1);
		chk(12'(n >= UTS_N - 2 && n <= UTS_N + 2), 12'h1);
		op(OP_LOAD_CMD, 12'h003);
		chk(12'(up_to_speed), 12'h1);
		op(OP_LOAD_CMD, 12'h000);
		tick(3 * UTS_N);
		chk(12'(up_to_speed), 12'h0);
	endtask
	task automatic t_read();
		word = 12'hA5C;
		mark = 6'h2D;
		op(OP_LOAD_CMD, 12'h00A);
		tick(UTS_N + 4);
		lines12(1'b1, OP_READ_DATA);
		op(OP_READ_CMD, 12'h000);
		chk(12'(ac_out[11:6]), 12'(mark));
		op(OP_LOAD_CMD, 12'h002);
		op(OP_READ_CMD, 12'h000);
		chk(12'(ac_out[11:6]), 12'h000);
	endtask
	task automatic t_write();
		int hit;
		word = 12'h3B6;
		tick(UTS_N + 4);
		op(OP_LOAD_CMD, 12'h003);
		op(OP_LOAD_DATA, word);
		tick(2);
		chk(12'(write_data_gate), 12'h1);
		lines12(1'b1, OP_LOAD_DATA);
		hit = 0;
		for (int j = 0; j <= 36; j += 3)
			if (wr_hist[j +: 12] === word)
				hit = 1;
		chk(12'(hit), 12'h1);
		write_lockout = 1'b1;
		tick(5);
		op(OP_READ_CMD, 12'h000);
		chk(12'({write_data_gate, ac_out[4:0]}), 12'h12);
		write_lockout = 1'b0;
		tick(4);
	endtask
	task automatic t_terr();
		op(OP_LOAD_CMD, 12'h003);
		lines12(1'b0, OP_LOAD_DATA);
		chk(12'({timing_error, write_data_gate}), 12'h2);
		op(OP_SKIP_LINE, 12'h000);
		chk(12'(skip), 12'h1);
		op(OP_SKIP_WORD, 12'h000);
		chk(12'(skip), 12'h1);
		op(OP_SKIP_TERR, 12'h000);
		chk(12'(skip), 12'h1);
		op(OP_READ_CMD, 12'h000);
		chk(12'({ac_out[5], line_done_flag, word_done_flag}), 12'h4);
		sel_err = 1'b1;
		op(OP_LOAD_CMD, 12'h002);
		tick(4);
		op(OP_READ_CMD, 12'h000);
		chk(12'({timing_error, ac_out[5]}), 12'h1);
		sel_err = 1'b0;
	endtask
	task automatic t_stop();
		tick(4);
		op(OP_LOAD_CMD, 12'h003);
		tick(1);
		chk(12'(write_data_gate), 12'h1);
		power_ok = 1'b0;
		tick(5);
		chk(12'(write_data_gate), 12'h0);
		power_ok = 1'b1;
		tick(4);
		op(OP_LOAD_CMD, 12'h003);
		proc_run = 1'b0;
		tick(6);
		chk(12'({stop_all, go, write_data_gate}), 12'h4);
		proc_run = 1'b1;
		tick(6);
		system_clear = 1'b1;
		tick(1);
		system_clear = 1'b0;
		op(OP_READ_CMD, 12'h000);
		chk(12'(ac_out[3:0]), 12'(CMD_RESET));
	endtask
	task automatic t_format();
		format_write_setting = 1'b1;
		op(OP_LOAD_CMD, 12'h003);
		tick(FMT_HALF_CYC - 10);
		chk(12'(write_timing_track), 12'h0);
		tick(20);
		chk(12'(write_timing_track), 12'h1);
		format_write_setting = 1'b0;
	endtask

	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	// Whole run is near 24 us; a hang stops at 1 ms
	initial
	begin
		#1000000;
		err_count++;
		wrap_up();
	end
	initial
	begin
		{arst_n, system_clear, io_pause, sel_err, write_lockout,
			format_write_setting} = 6'h00;
		{md_dev, md_op, data_bus, word, mark} = 35'h0;
		{power_ok, proc_run} = 2'h3;
		line_limit = 32'h0;
		err_count = 0;
		n_compared = 0;
		repeat (20) @(posedge core_clk);
		#1 arst_n = 1'b1;
		tick(4);
		t_decode();
		t_cmd();
		t_uts();
		t_read();
		t_write();
		t_terr();
		t_stop();
		t_format();
		wrap_up();
	end
endmodule

bind stc_ctrl stc_ctrl_chk i_chk (.core_clk, .arst_n, .clk_en,
	.system_clear, .io_pause, .md_dev, .md_op, .code_select_bit_a,
	.code_select_bit_b, .data_bus, .internal_io, .instr_decode_enable,
	.skip, .ac_load, .ac_out, .unit_sel, .dir_reverse, .go, .stop_all,
	.write_data_gate, .write_track0, .write_track1, .write_track2,
	.up_to_speed, .line_done_flag, .word_done_flag, .timing_error);
